// [verilog/ldsb_pkg.sv]
package ldsb_pkg;
    // system clock and display timing
    localparam int CLK_HZ = 25000000;
    localparam int SCAN_HZ = 500;
    localparam int DIGIT_NS = 244000;
    localparam int BLANK_NS = 6000;
    localparam int NUM_DIGITS = 8;
    localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    // slot of one digit = on time + blanking gap (250 us)
    localparam int SLOT_CYCLES = CLK_HZ / (SCAN_HZ * NUM_DIGITS);
    // least time rounds up
    localparam int BLANK_CYCLES = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest on time rounds down
    localparam int DIGIT_CYCLES = DIGIT_NS / CLK_PERIOD_NS;
    // measurement spacing, 200 ms at nominal rate
    localparam int MEAS_MS = 200;
    localparam int MEAS_CYCLES = MEAS_MS * (CLK_HZ / 1000);
    localparam int TB_DIV = 1;
    localparam logic [3:0] DP_RESET = 4'h0;
    localparam logic [2:0] MSD_POS = 3'h7;
    typedef enum logic [1:0] {LDSB_BLANK, LDSB_SHOW} ldsb_phase_t;
endpackage

// [verilog/ldsb_timebase.sv]
`timescale 1ns/1ps
module ldsb_timebase #(
    parameter int DIV = ldsb_pkg::TB_DIV
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic tick
);
    import ldsb_pkg::*;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    initial begin
        if (DIV < 1 || DIV > 255) $error("ldsb_timebase: DIV out of range");
    end
    always_comb begin
        cnt_next = cnt_reg + 8'h01;
        tick_next = 1'b0;
        if (cnt_reg == 8'(DIV - 1)) begin
            cnt_next = 8'h00;
            tick_next = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end
    assign tick = (DIV == 1) ? 1'b1 : tick_reg;
endmodule

// [verilog/ldsb_scan.sv]
`timescale 1ns/1ps
module ldsb_scan #(
    parameter int TB_DIV = ldsb_pkg::TB_DIV,
    parameter int SLOT = ldsb_pkg::SLOT_CYCLES,
    parameter int BLANK = ldsb_pkg::BLANK_CYCLES,
    parameter int MEAS = ldsb_pkg::MEAS_CYCLES,
    parameter bit EXT_DP_EN = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] count_bcd,
    input wire logic [3:0] dp_pos,
    input wire logic [3:0] dp_internal,
    input wire logic overflow,
    output logic [7:0] digit_en,
    output logic [7:0] segments,
    output logic meas_gate
);
    import ldsb_pkg::*;
    initial begin
        if (BLANK < 1 || SLOT <= BLANK || MEAS < 2) $error("ldsb_scan: bad timing parameters");
        if (SLOT > 32'h000F_FFFF) $error("ldsb_scan: slot counter too narrow for SLOT");
    end
    logic tick;
    ldsb_timebase #(.DIV(TB_DIV)) u_tb (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );
    logic [19:0] slot_reg, slot_next;
    logic [2:0] pos_reg, pos_next;
    logic [31:0] meas_reg, meas_next;
    logic gate_reg, gate_next;
    logic [7:0] den_reg, den_next;
    logic [7:0] seg_reg, seg_next;
    logic [3:0] nib;
    logic [3:0] dp_eff;
    logic [7:0] nz_above;
    logic show;
    logic [2:0] pos_adv;
    // next position in scan order
    assign pos_adv = pos_reg + 3'h1;
    function automatic logic [6:0] font(input logic [3:0] v);
        case (v)
            4'h0: font = 7'h3f;
            4'h1: font = 7'h06;
            4'h2: font = 7'h5b;
            4'h3: font = 7'h4f;
            4'h4: font = 7'h66;
            4'h5: font = 7'h6d;
            4'h6: font = 7'h7d;
            4'h7: font = 7'h07;
            4'h8: font = 7'h7f;
            4'h9: font = 7'h6f;
            default: font = 7'h00;
        endcase
    endfunction
    // nonzero digit at or above each position
    genvar g;
    generate
        for (g = 0; g < NUM_DIGITS; g++) begin : g_nz
            if (g == NUM_DIGITS - 1) begin : g_top
                assign nz_above[g] = |count_bcd[4*g +: 4];
            end else begin : g_rest
                assign nz_above[g] = (|count_bcd[4*g +: 4]) | nz_above[g+1];
            end
        end
    endgenerate
    always_comb begin
        dp_eff = EXT_DP_EN ? dp_pos : dp_internal;
        nib = count_bcd[4*pos_adv +: 4];
        show = 1'b1;
        if (!nz_above[pos_adv] && {1'b0, pos_adv} != dp_eff) begin
            show = 1'b0;
        end
        if ({1'b0, pos_adv} < dp_eff) begin
            show = 1'b1;
        end
        if (overflow) begin
            show = 1'b1;
        end
    end
    always_comb begin
        slot_next = slot_reg;
        pos_next = pos_reg;
        den_next = den_reg;
        seg_next = seg_reg;
        if (tick) begin
            if (slot_reg == 20'(SLOT - 1)) begin
                slot_next = 20'h0_0000;
            end else begin
                slot_next = slot_reg + 20'h0_0001;
            end
            if (slot_reg == 20'(SLOT - 1)) begin
                den_next = 8'h00;
                seg_next = 8'h00;
            end else if (slot_reg == 20'(BLANK - 1)) begin
                pos_next = pos_adv;
                den_next = 8'h01 << pos_adv;
                seg_next[6:0] = show ? font(nib) : 7'h00;
                seg_next[7] = (pos_adv == MSD_POS) ? overflow : (dp_eff == {1'b0, pos_adv});
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slot_reg <= 20'h0_0000;
            pos_reg <= MSD_POS;
            den_reg <= 8'h00;
            seg_reg <= 8'h00;
        end else begin
            slot_reg <= slot_next;
            pos_reg <= pos_next;
            den_reg <= den_next;
            seg_reg <= seg_next;
        end
    end
    always_comb begin
        meas_next = meas_reg;
        gate_next = gate_reg;
        if (tick) begin
            if (meas_reg == 32'(MEAS - 1)) begin
                meas_next = 32'h0000_0000;
                gate_next = ~gate_reg;
            end else begin
                meas_next = meas_reg + 32'h0000_0001;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meas_reg <= 32'h0000_0000;
            gate_reg <= 1'b0;
        end else begin
            meas_reg <= meas_next;
            gate_reg <= gate_next;
        end
    end
    assign digit_en = den_reg;
    assign segments = seg_reg;
    assign meas_gate = gate_reg;
    logic [19:0] on_cnt_reg;
    logic [19:0] on_cnt_next;
    always_comb begin
        on_cnt_next = on_cnt_reg;
        if (den_reg == 8'h00) begin
            on_cnt_next = 20'h0_0000;
        end else if (tick) begin
            on_cnt_next = on_cnt_reg + 20'h0_0001;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            on_cnt_reg <= 20'h0_0000;
        end else begin
            on_cnt_reg <= on_cnt_next;
        end
    end
    a_onehot_digit: assert property (@(posedge sys_clk) disable iff (rst) $onehot0(den_reg))
        else $error("more than one digit selected");
    a_gap_blank: assert property (@(posedge sys_clk) disable iff (rst)
        (slot_reg < 20'(BLANK)) |-> (den_reg == 8'h00 && seg_reg == 8'h00))
        else $error("outputs active during blanking gap");
    a_ovf_point: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && slot_reg == 20'(BLANK - 1) && pos_adv == MSD_POS) |=> seg_reg[7] == $past(overflow))
        else $error("overflow point wrong on top digit");
    a_scan_order: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(den_reg[0]) |-> $past(pos_reg) == 3'h7)
        else $error("scan order broken");
    a_gate_period: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(gate_reg) |-> meas_reg == 32'h0000_0000)
        else $error("gate toggled off schedule");
    a_ovf_show: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && overflow && slot_reg == 20'(BLANK - 1)) |=> seg_reg[6:0] != 7'h00)
        else $error("digit blanked under overflow");
    a_lead_blank: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && slot_reg == 20'(BLANK - 1) && !overflow && {1'b0, pos_adv} > dp_eff
            && (count_bcd >> (4 * pos_adv)) == 32'h0000_0000) |=> seg_reg[6:0] == 7'h00)
        else $error("leading zero not blanked");
    a_frac_shown: assert property (@(posedge sys_clk) disable iff (rst)
        (tick && slot_reg == 20'(BLANK - 1) && {1'b0, pos_adv} < dp_eff) |=> seg_reg[6:0] != 7'h00)
        else $error("digit right of point blanked");
    a_on_time: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(|den_reg) |-> $past(on_cnt_reg) == 20'(SLOT - BLANK - 1))
        else $error("digit on time wrong");
    a_slot_range: assert property (@(posedge sys_clk) disable iff (rst)
        slot_reg < 20'(SLOT))
        else $error("slot counter out of range");
    a_digit_hold: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(den_reg) |-> ($past(tick) && ($past(slot_reg) == 20'(SLOT - 1) || $past(slot_reg) == 20'(BLANK - 1))))
        else $error("digit select changed mid slot");
endmodule

// [verification/ldsb_led_model.sv]
`timescale 1ns/1ps
module ldsb_led_model (
    input wire logic sys_clk,
    input wire logic [7:0] digit_en,
    input wire logic [7:0] segments
);
    logic [7:0] seen [8];
    logic [7:0] last_dig = 8'h00;
    int on_len = 0;
    int gap_len = 0;
    int last_on = 0;
    int last_gap = 0;
    int bad_sel = 0;
    always @(posedge sys_clk) begin
        if (digit_en == 8'h00) begin
            if (segments != 8'h00) bad_sel++;
            if (on_len != 0) last_on = on_len;
            on_len = 0;
            gap_len++;
        end else begin
            if ($countones(digit_en) != 1) bad_sel++;
            if (on_len == 0) begin
                last_gap = gap_len;
                if (last_dig != 8'h00 && digit_en != {last_dig[6:0], last_dig[7]}) bad_sel++;
                last_dig = digit_en;
            end else if (digit_en != last_dig) begin
                bad_sel++;
            end
            gap_len = 0;
            on_len++;
            for (int i = 0; i < 8; i++) if (digit_en[i]) seen[i] = segments;
        end
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
    import ldsb_pkg::*;
    localparam int SL = 20;
    localparam int BL = 3;
    localparam int MS = 50;
    localparam logic [6:0] FONT [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] count_bcd = 32'h0000_0000;
    logic [3:0] dp_real = 4'h0;
    logic [3:0] dp_junk = 4'h3;
    logic overflow = 1'b0;
    logic [7:0] en1, seg1, en2, seg2;
    logic gate1, gate2, gate_prev, gate2_prev;
    logic [31:0] rnd = 32'h6ed5;
    int num_errors = 0;
    int checked = 0;
    int gate_len = 0;
    int gate_cnt = 0;
    int gate2_len = 0;
    int gate2_cnt = 0;
    ldsb_scan #(.TB_DIV(1), .SLOT(SL), .BLANK(BL), .MEAS(MS), .EXT_DP_EN(1'b1)) DUT (.sys_clk(sys_clk),
        .rst(rst), .count_bcd(count_bcd), .dp_pos(dp_real), .dp_internal(dp_junk), .overflow(overflow),
        .digit_en(en1), .segments(seg1), .meas_gate(gate1));
    ldsb_scan #(.TB_DIV(4), .SLOT(SL), .BLANK(BL), .MEAS(MS), .EXT_DP_EN(1'b0)) DUT_Q (.sys_clk(sys_clk),
        .rst(rst), .count_bcd(count_bcd), .dp_pos(dp_junk), .dp_internal(dp_real), .overflow(overflow),
        .digit_en(en2), .segments(seg2), .meas_gate(gate2));
    ldsb_led_model led1 (.sys_clk(sys_clk), .digit_en(en1), .segments(seg1));
    ldsb_led_model led2 (.sys_clk(sys_clk), .digit_en(en2), .segments(seg2));
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        gate_cnt++;
        gate2_cnt++;
        if (gate1 !== gate_prev) begin
            gate_len = gate_cnt;
            gate_cnt = 0;
        end
        if (gate2 !== gate2_prev) begin
            gate2_len = gate2_cnt;
            gate2_cnt = 0;
        end
        gate_prev = gate1;
        gate2_prev = gate2;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] exp_seg(input logic [31:0] c, input int dp, input bit ov, input int n);
        bit lead;
        lead = !ov && n > dp && (c >> (4 * n)) == 0;
        return {(n == 7) ? ov : (n == dp), lead ? 7'h00 : FONT[c[4*n +: 4]]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic run_case(input logic [31:0] c, input logic [3:0] dp, input bit ov);
        @(posedge sys_clk);
        count_bcd <= c;
        dp_real <= dp;
        dp_junk <= dp ^ 4'h3;
        overflow <= ov;
        repeat (2 * NUM_DIGITS * SL * 4 + 8) @(posedge sys_clk);
        for (int n = 0; n < 8; n++) begin
            check("segments", led1.seen[n], exp_seg(c, dp, ov, n));
            check("segments_fixed_point", led2.seen[n], exp_seg(c, dp, ov, n));
        end
        $display("test case %0h done", c);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] c;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        run_case(32'h0000_0000, 4'h0, 1'b0);
        run_case(32'h0000_0000, 4'h3, 1'b0);
        run_case(32'h0000_0100, 4'h1, 1'b0);
        run_case(32'h0000_0000, 4'h0, 1'b1);
        run_case(32'h9876_5432, 4'h6, 1'b1);
        for (int k = 0; k < 5; k++) begin
            for (int d = 0; d < 8; d++) begin
                rnd = xs(rnd);
                c[4*d +: 4] = 4'(rnd % 10);
            end
            rnd = xs(rnd);
            run_case(c >> (4 * (rnd % 8)), 4'(rnd % 7), rnd[8]);
        end
        check("on_time", led1.last_on, SL - BL);
        check("gap_time", led1.last_gap, BL);
        check("on_time_quarter", led2.last_on, (SL - BL) * 4);
        check("gap_time_quarter", led2.last_gap, BL * 4);
        check("gate_spacing", gate_len, MS);
        check("gate_spacing_quarter", gate2_len, MS * 4);
        check("select_faults", led1.bad_sel + led2.bad_sel, 0);
        final_report();
    end
endmodule
